// ---- bsd_discriminator.sv ----
`timescale 1ns/10ps
// Overview of operation
// RULE1: mode field picks off, window, continuous, test
// RULE2: each adjustment moves code by step+1
// RULE3: sample every (period code+1) times 18.88 us
// RULE4: upper threshold code drives comparator, linear scale
// RULE5: sampling period register resets to zero
// RULE6: lower threshold uses same linear scale
// RULE7: window: below raises, above lowers, saturating
module bsd_discriminator #(
	parameter int SAMPLE_UNIT_CYCLES = bsd_pkg::SAMPLE_UNIT_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] vbst_code,
	input  wire logic       sense_above_upper,
	input  wire logic       sense_below_lower,
	output logic      [7:0] upper_threshold_code,
	output logic      [7:0] lower_threshold_code,
	output logic      [7:0] dac_code
);
	logic [7:0] mode_step;
	logic [7:0] next_mode_step;
	logic [7:0] sampling_period_code;
	logic [7:0] next_sampling_period_code;
	logic [7:0] next_upper;
	logic [7:0] next_lower;
	logic [7:0] next_dac;
	logic [7:0] next_rdata;
	logic       above_meta;
	logic       above_sync;
	logic       below_meta;
	logic       below_sync;
	logic [1:0] discriminator_mode;
	logic [2:0] dac_adjust_step;
	logic [8:0] step9;
	logic [8:0] up9;
	logic [7:0] raised;
	logic [7:0] lowered;

	localparam int MODE_MSB_I = bsd_pkg::MODE_MSB;
	localparam int MODE_LSB_I = bsd_pkg::MODE_LSB;
	localparam int STEP_MSB_I = bsd_pkg::STEP_MSB;
	localparam int STEP_LSB_I = bsd_pkg::STEP_LSB;

	// field split of the mode and step register
	assign discriminator_mode = mode_step[MODE_MSB_I:MODE_LSB_I];
	assign dac_adjust_step    = mode_step[STEP_MSB_I:STEP_LSB_I];

	// sampling time base
	bsd_tick_if tick_bus ();
	assign tick_bus.period_code = sampling_period_code;

	bsd_sample_timer #(
		.UNIT_CYCLES (SAMPLE_UNIT_CYCLES)
	) u_timer (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.tif     (tick_bus.timer)
	);

	// comparator pins cross into the clock domain
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			above_meta <= 1'b0;
			above_sync <= 1'b0;
			below_meta <= 1'b0;
			below_sync <= 1'b0;
		end else begin
			above_meta <= sense_above_upper;
			above_sync <= above_meta;
			below_meta <= sense_below_lower;
			below_sync <= below_meta;
		end
	end

	// step arithmetic with saturation at 0 and at the boost clamp
	always_comb begin
		step9   = {6'h00, dac_adjust_step} + 9'h001; // [RULE2]
		up9     = {1'b0, dac_code} + step9;
		raised  = (up9 > {1'b0, vbst_code}) ? vbst_code : up9[7:0]; // [RULE7]
		lowered = ({1'b0, dac_code} < step9) ? 8'h00 : dac_code - step9[7:0]; // [RULE7]
	end

	// register writes, reads and dac code update
	always_comb begin
		next_mode_step            = mode_step;
		next_sampling_period_code = sampling_period_code;
		next_upper                = upper_threshold_code;
		next_lower                = lower_threshold_code;
		next_rdata                = reg_rdata;
		next_dac                  = dac_code;
		if (reg_wr) begin
			case (reg_addr)
				bsd_pkg::ADDR_MODE_STEP: next_mode_step = reg_wdata & bsd_pkg::MODE_STEP_MASK;
				bsd_pkg::ADDR_PERIOD:    next_sampling_period_code = reg_wdata;
				bsd_pkg::ADDR_UPPER:     next_upper = reg_wdata; // [RULE4]
				bsd_pkg::ADDR_LOWER:     next_lower = reg_wdata; // [RULE6]
				default:                 next_mode_step = mode_step;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				bsd_pkg::ADDR_MODE_STEP: next_rdata = mode_step;
				bsd_pkg::ADDR_PERIOD:    next_rdata = sampling_period_code;
				bsd_pkg::ADDR_UPPER:     next_rdata = upper_threshold_code;
				bsd_pkg::ADDR_LOWER:     next_rdata = lower_threshold_code;
				bsd_pkg::ADDR_STATUS:    next_rdata = dac_code;
				default:                 next_rdata = 8'h00;
			endcase
		end
		case (discriminator_mode) // [RULE1]
			bsd_pkg::MODE_OFF: begin
				next_dac = vbst_code; // follows the programmed boost code
			end
			bsd_pkg::MODE_WINDOW: begin
				if (tick_bus.tick) begin
					if (below_sync)
						next_dac = raised; // [RULE7]
					else if (above_sync)
						next_dac = lowered; // [RULE7]
				end
			end
			bsd_pkg::MODE_CONTINUOUS: begin
				if (tick_bus.tick)
					next_dac = above_sync ? lowered : raised;
			end
			bsd_pkg::MODE_TEST: begin
				next_dac = dac_code; // frozen for inspection
			end
			default: begin
				next_dac = dac_code;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_step            <= bsd_pkg::RST_MODE_STEP; // [RULE1]
			sampling_period_code <= bsd_pkg::RST_PERIOD; // [RULE5]
			upper_threshold_code <= bsd_pkg::RST_UPPER;
			lower_threshold_code <= bsd_pkg::RST_LOWER;
			dac_code             <= bsd_pkg::RST_DAC;
			reg_rdata            <= 8'h00;
		end else begin
			mode_step            <= next_mode_step;
			sampling_period_code <= next_sampling_period_code;
			upper_threshold_code <= next_upper;
			lower_threshold_code <= next_lower;
			dac_code             <= next_dac;
			reg_rdata            <= next_rdata;
		end
	end

	// helper: first cycle after reset release
	logic out_of_reset;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			out_of_reset <= 1'b0;
		else
			out_of_reset <= 1'b1;
	end

	chk_off_follows_boost: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
		(discriminator_mode == bsd_pkg::MODE_OFF) |=> dac_code == $past(vbst_code))
		else $error("off mode does not follow boost code");

	chk_test_holds_code: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
		(discriminator_mode == bsd_pkg::MODE_TEST) |=> $stable(dac_code))
		else $error("test mode changed dac code");

	chk_step_raise_size: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE2]
		(discriminator_mode == bsd_pkg::MODE_WINDOW && tick_bus.tick && below_sync && up9 <= {1'b0, vbst_code})
		|=> dac_code == $past(dac_code) + {5'h00, $past(dac_adjust_step)} + 8'h01)
		else $error("raise step size wrong");

	chk_window_lower: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
		(discriminator_mode == bsd_pkg::MODE_WINDOW && tick_bus.tick && !below_sync && above_sync)
		|=> dac_code == (($past(dac_code) > {5'h00, $past(dac_adjust_step)})
			? $past(dac_code) - {5'h00, $past(dac_adjust_step)} - 8'h01 : 8'h00))
		else $error("window lowering wrong");

	chk_raise_clamp: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
		(discriminator_mode == bsd_pkg::MODE_WINDOW && tick_bus.tick && below_sync && up9 > {1'b0, vbst_code})
		|=> dac_code == $past(vbst_code))
		else $error("window raise not clamped");

	chk_window_idle: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
		(discriminator_mode == bsd_pkg::MODE_WINDOW && tick_bus.tick && !below_sync && !above_sync) |=> $stable(dac_code))
		else $error("window moved code inside band");

	chk_cont_raise: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE2]
		(discriminator_mode == bsd_pkg::MODE_CONTINUOUS && tick_bus.tick && !above_sync && up9 <= {1'b0, vbst_code})
		|=> dac_code == $past(dac_code) + {5'h00, $past(dac_adjust_step)} + 8'h01)
		else $error("continuous raise step wrong");

	chk_cont_lower: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
		(discriminator_mode == bsd_pkg::MODE_CONTINUOUS && tick_bus.tick && above_sync)
		|=> dac_code <= $past(dac_code))
		else $error("continuous mode raised while above");

	chk_mode_mask: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
		(reg_wr && reg_addr == bsd_pkg::ADDR_MODE_STEP)
		|=> mode_step[7:5] == 3'h0 && mode_step[4:0] == $past(reg_wdata[4:0]))
		else $error("mode and step write wrong");

	chk_status_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
		(reg_rd && reg_addr == bsd_pkg::ADDR_STATUS) |=> reg_rdata == $past(dac_code))
		else $error("status read wrong");

	chk_window_no_tick: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
		(discriminator_mode == bsd_pkg::MODE_WINDOW && !tick_bus.tick) |=> $stable(dac_code))
		else $error("window changed code without sample");

	chk_period_after_reset: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE5]
		!out_of_reset |-> sampling_period_code == 8'h00)
		else $error("sampling period not zero after reset");

	chk_upper_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE4]
		(reg_wr && reg_addr == bsd_pkg::ADDR_UPPER) |=> upper_threshold_code == $past(reg_wdata))
		else $error("upper threshold write lost");

	chk_lower_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE6]
		(reg_wr && reg_addr == bsd_pkg::ADDR_LOWER) ##1 !reg_wr [*2]
		|-> $stable(lower_threshold_code) && lower_threshold_code == $past(reg_wdata, 2))
		else $error("lower threshold not held");
endmodule // bsd_discriminator

// ---- bsd_pkg.sv ----
package bsd_pkg;
	// register offsets on the internal register port
	localparam logic [7:0] ADDR_MODE_STEP  = 8'h1c;
	localparam logic [7:0] ADDR_PERIOD     = 8'h1d;
	localparam logic [7:0] ADDR_UPPER      = 8'h1e;
	localparam logic [7:0] ADDR_LOWER      = 8'h1f;
	localparam logic [7:0] ADDR_STATUS     = 8'h2f;
	// reset values
	localparam logic [7:0] RST_MODE_STEP   = 8'h00;
	localparam logic [7:0] RST_PERIOD      = 8'h00;
	localparam logic [7:0] RST_UPPER       = 8'h01;
	localparam logic [7:0] RST_LOWER       = 8'h00;
	localparam logic [7:0] RST_DAC         = 8'h00;
	// field layout of the mode and step register
	localparam int         STEP_LSB        = 0;
	localparam int         STEP_MSB        = 2;
	localparam int         MODE_LSB        = 3;
	localparam int         MODE_MSB        = 4;
	localparam logic [7:0] MODE_STEP_MASK  = 8'h1f;
	// discriminator mode codes
	localparam logic [1:0] MODE_OFF        = 2'h0;
	localparam logic [1:0] MODE_WINDOW     = 2'h1;
	localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
	localparam logic [1:0] MODE_TEST       = 2'h3;
	// threshold scale, informational for the analog side: 14.084 mV per code
	localparam int         THRESH_STEP_UV  = 14084;
	// sampling time base
	localparam real        CLK_PERIOD_NS   = 40.0;
	localparam real        SAMPLE_UNIT_US  = 18.88;
	// rounded, not truncated: the real quotient may land a hair under 472
	localparam int         SAMPLE_UNIT_CYCLES = int'(SAMPLE_UNIT_US * 1000.0 / CLK_PERIOD_NS);
endpackage

// ---- bsd_tick_if.sv ----
`timescale 1ns/10ps
interface bsd_tick_if;
	logic [7:0] period_code;
	logic       tick;
	modport timer (input period_code, output tick);
	modport ctrl  (output period_code, input tick);
endinterface

// ---- bsd_sample_timer.sv ----
`timescale 1ns/10ps
module bsd_sample_timer #(
	parameter int UNIT_CYCLES = bsd_pkg::SAMPLE_UNIT_CYCLES
) (
	input  wire logic  sys_clk,
	input  wire logic  arst_n,
	bsd_tick_if.timer  tif
);
	localparam int UW = $clog2(UNIT_CYCLES + 1);
	localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CYCLES - 1);

	logic [UW-1:0] unit_cnt;
	logic [UW-1:0] next_unit_cnt;
	logic [7:0]    per_cnt;
	logic [7:0]    next_per_cnt;
	logic          tick;
	logic          next_tick;

	// unit prescaler and period counter, one tick per (code+1) units
	always_comb begin
		next_unit_cnt = unit_cnt + UW'(1);
		next_per_cnt  = per_cnt;
		next_tick     = 1'b0;
		if (unit_cnt == UNIT_LAST) begin
			next_unit_cnt = '0;
			if (per_cnt >= tif.period_code) begin // [RULE3]
				next_per_cnt = 8'h00;
				next_tick    = 1'b1;
			end else begin
				next_per_cnt = per_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			unit_cnt <= '0;
			per_cnt  <= 8'h00;
			tick     <= 1'b0;
		end else begin
			unit_cnt <= next_unit_cnt;
			per_cnt  <= next_per_cnt;
			tick     <= next_tick;
		end
	end

	assign tif.tick = tick;

	// helper: gap between ticks while the period code is steady
	logic [17:0] gap;
	logic        gap_valid;
	logic [7:0]  code_seen;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gap       <= 18'h00000;
			gap_valid <= 1'b0;
			code_seen <= 8'h00;
		end else begin
			code_seen <= tif.period_code;
			gap       <= tick ? 18'h00001 : gap + 18'h00001;
			if (code_seen != tif.period_code)
				gap_valid <= 1'b0;
			else if (tick)
				gap_valid <= 1'b1;
		end
	end

	chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE3]
		(tick && gap_valid && code_seen == tif.period_code)
		|-> gap == 18'((int'(tif.period_code) + 1) * UNIT_CYCLES))
		else $error("sample tick spacing wrong");
endmodule // bsd_sample_timer

// ---- bsd_discriminator_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module bsd_discriminator_tb;
	localparam int UNIT = 4;
	logic       sys_clk;
	logic       arst_n;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] vbst_code;
	logic       sense_above_upper;
	logic       sense_below_lower;
	logic [7:0] upper_threshold_code;
	logic [7:0] lower_threshold_code;
	logic [7:0] dac_code;
	int         errors;
	int         checked;
	int         cycles;
	int         n;
	logic [7:0] prev;
	// rows: address, write data, expected read back
	logic [23:0] rows [0:4] = '{24'h1c_ff_1f, 24'h1d_5a_5a, 24'h1e_80_80, 24'h1f_3c_3c, 24'h30_55_00};

	bsd_discriminator #(.SAMPLE_UNIT_CYCLES(UNIT)) i_bsd_discriminator (
		.sys_clk              (sys_clk),
		.arst_n               (arst_n),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.vbst_code            (vbst_code),
		.sense_above_upper    (sense_above_upper),
		.sense_below_lower    (sense_below_lower),
		.upper_threshold_code (upper_threshold_code),
		.lower_threshold_code (lower_threshold_code),
		.dac_code             (dac_code)
	);

	// clock generation
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask

	// read strobe, data checked one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		@(negedge sys_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		`CHK("reg_rdata", ex, reg_rdata)
	endtask

	// cycles until dac_code moves, bounded
	task automatic wait_change(output int cnt);
		logic [7:0] d;
		d = dac_code;
		cnt = 0;
		while (dac_code === d && cnt < 200) begin
			@(negedge sys_clk);
			cnt++;
		end
		if (cnt >= 200) begin
			errors++;
			$display("ERROR dac_code never moved");
		end
	endtask

	initial begin
		errors = 0; checked = 0; cycles = 0;
		arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
		vbst_code = 8'h20; sense_above_upper = 1'b0; sense_below_lower = 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK("upper_rst", 8'h01, upper_threshold_code)
		`CHK("lower_rst", 8'h00, lower_threshold_code)
		`CHK("dac_rst", 8'h00, dac_code)
		arst_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		`CHK("dac_off", 8'h20, dac_code)
		rd(8'h1c, 8'h00);
		rd(8'h1d, 8'h00);
		rd(8'h1e, 8'h01);
		rd(8'h1f, 8'h00);
		// ordinary register rows
		for (int i = 0; i < 5; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		`CHK("upper_out", 8'h80, upper_threshold_code)
		`CHK("lower_out", 8'h3c, lower_threshold_code)
		wr(8'h1c, 8'h00);
		wr(8'h2f, 8'h77);
		rd(8'h2f, 8'h20);
		// window, above upper: lower by step 2+1 every 2 units
		sense_above_upper = 1'b1;
		wr(8'h1d, 8'h01);
		wr(8'h1c, 8'h0a);
		wait_change(n);
		prev = dac_code;
		wait_change(n);
		`CHK("dac_step3", prev - 8'h03, dac_code)
		`CHK("period", 8'(2 * UNIT), 8'(n))
		wr(8'h1c, 8'h0f);
		repeat (80) @(negedge sys_clk);
		`CHK("dac_floor", 8'h00, dac_code)
		// both flags: raising wins, clamps at vbst_code
		sense_below_lower = 1'b1;
		repeat (100) @(negedge sys_clk);
		`CHK("dac_ceiling", 8'h20, dac_code)
		sense_above_upper = 1'b0;
		sense_below_lower = 1'b0;
		repeat (5) @(negedge sys_clk);
		prev = dac_code;
		repeat (40) @(negedge sys_clk);
		`CHK("dac_hold", prev, dac_code)
		// continuous mode, step 0+1
		sense_above_upper = 1'b1;
		wr(8'h1c, 8'h10);
		wait_change(n);
		prev = dac_code;
		wait_change(n);
		`CHK("cont_down", prev - 8'h01, dac_code)
		sense_above_upper = 1'b0;
		repeat (20) @(negedge sys_clk);
		wr(8'h1c, 8'h10);
		`CHK("cont_up", 8'h20, dac_code)
		// test mode freezes
		wr(8'h1c, 8'h18);
		sense_above_upper = 1'b1;
		prev = dac_code;
		repeat (40) @(negedge sys_clk);
		`CHK("test_freeze", prev, dac_code)
		// off mode tracks vbst_code
		wr(8'h1c, 8'h00);
		vbst_code = 8'h33;
		repeat (3) @(negedge sys_clk);
		`CHK("off_track", 8'h33, dac_code)
		// reset in mid-run: registers return to defaults
		@(negedge sys_clk);
		arst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		`CHK("dac_rst2", 8'h00, dac_code)
		arst_n = 1'b1;
		rd(8'h1d, 8'h00);
		rd(8'h1c, 8'h00);
		`CHK("upper_rst2", 8'h01, upper_threshold_code)
		`CHK("dac_off2", 8'h33, dac_code)
		print_verdict();
	end
endmodule // bsd_discriminator_tb
